// [src/rvq_top.sv]
// Ring validation qualifier with classic Wishbone register slave
`timescale 1ns/1ps
module rvq_top
   import rvq_pkg::*;
#(
   parameter int TICK_CYCLES_P = rvq_pkg::TICK_CYCLES
) (
   input  wire logic                      clk_i,        // 250 MHz clock
   input  wire logic                      rst_i,        // Synchronous reset, high
   input  wire logic                      wb_cyc_i,     // Bus cycle
   input  wire logic                      wb_stb_i,     // Strobe
   input  wire logic                      wb_we_i,      // Write enable
   input  wire logic [rvq_pkg::WB_AW-1:0] wb_adr_i,     // Byte address
   input  wire logic [3:0]                wb_sel_i,     // Byte lanes
   input  wire logic [rvq_pkg::WB_DW-1:0] wb_dat_i,     // Write data
   output logic      [rvq_pkg::WB_DW-1:0] wb_dat_o,     // Read data
   output logic                           wb_ack_o,     // Acknowledge
   input  wire logic                      ring_event_i, // Tip/ring crossing pulse
   output logic                           ring_valid_o, // Validated ring level
   output logic                           irq_o         // Interrupt level
);
   import rvq_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   rvq_cfg_t         cfg;
   rvq_state_t       state;
   logic [ST_W-1:0]  status;
   logic [ST_W-1:0]  mask;
   logic [ST_W-1:0]  next_events;
   logic [5:0]       timer;
   logic [CNT_W-1:0] conf_cnt;
   logic [CNT_W-1:0] dly_cnt;
   logic [CNT_W-1:0] sil_cnt;
   logic             tick;
   logic             bus_req;
   logic             bus_wr;
   logic             bus_rd_status;
   logic             too_fast;
   logic             confirm_done;
   logic             silence_hit;
   logic [2:0]       delay_code;
   logic [7:0]       rd_byte;

   // ****************************************************************
   // Step enable
   // ****************************************************************
   rvq_tick #(
      .DIV (TICK_CYCLES_P)
   ) u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (tick)
   );

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   // Request sits for one cycle, then ack; writes and read clears land on the ack edge
   assign bus_req       = wb_cyc_i && wb_stb_i;
   assign bus_wr        = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0];
   assign bus_rd_status = bus_req && wb_ack_o && !wb_we_i && (wb_adr_i == ADDR_STATUS);

   // Ack one cycle after the strobe, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= bus_req && !wb_ack_o;
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      case (wb_adr_i)
         ADDR_CTRL1:  rd_byte = {cfg.delay_low, cfg.threshold};
         ADDR_CTRL2:  rd_byte = {cfg.delay_high, cfg.timeout, cfg.confirm};
         ADDR_CTRL3:  rd_byte = {cfg.enable, 1'b0, cfg.start};
         ADDR_STATUS: rd_byte = {5'h00, status};
         ADDR_MASK:   rd_byte = {5'h00, mask};
         ADDR_STATE:  rd_byte = {ring_valid_o, 3'h0, state};
         default:     rd_byte = 8'h00;
      endcase
   end

   // Read data registered as ack rises, so it is stable while ack is high
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= '0;
      else if (bus_req && !wb_ack_o && !wb_we_i)
         wb_dat_o <= {24'h000000, rd_byte};
      else if (!bus_req)
         wb_dat_o <= '0;
   end

   // Configuration registers; reserved bit of the third one is dropped
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         {cfg.delay_low, cfg.threshold}               <= CTRL1_RESET;
         {cfg.delay_high, cfg.timeout, cfg.confirm}   <= CTRL2_RESET;
         {cfg.enable, cfg.start}                      <= {CTRL3_RESET[7], CTRL3_RESET[5:0]};
      end
      else if (bus_wr)
      begin
         case (wb_adr_i)
            ADDR_CTRL1: {cfg.delay_low, cfg.threshold}             <= wb_dat_i[7:0];
            ADDR_CTRL2: {cfg.delay_high, cfg.timeout, cfg.confirm} <= wb_dat_i[7:0];
            ADDR_CTRL3: {cfg.enable, cfg.start}                    <= {wb_dat_i[7], wb_dat_i[5:0]};
            default:    ;
         endcase
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mask <= '0;
      else if (bus_wr && wb_adr_i == ADDR_MASK)
         mask <= wb_dat_i[ST_W-1:0];
   end

   // Sticky status; a new event in the clearing cycle survives the read
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status <= '0;
      else if (bus_rd_status)
         status <= next_events;
      else
         status <= status | next_events;
   end

   // Level interrupt from any unmasked sticky bit
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(status & mask);
   end

   // ****************************************************************
   // Qualifier
   // ****************************************************************
   // Too fast when spacing was shorter than start minus threshold steps
   assign too_fast     = timer > cfg.threshold;
   assign confirm_done = conf_cnt == '0;
   assign silence_hit  = sil_cnt >= timeout_ticks(cfg.timeout);
   assign delay_code   = {cfg.delay_high, cfg.delay_low};

   // Events raised this cycle, fed to the sticky status
   always_comb
   begin
      next_events = '0;
      if (state == S_QUAL && ring_event_i && too_fast)
         next_events[ST_FAST] = 1'b1;
      if (!ring_event_i && silence_hit && state == S_VALID)
         next_events[ST_END] = 1'b1;
      if (state == S_QUAL && !ring_event_i && !silence_hit && confirm_done && delay_code == 3'h0)
         next_events[ST_VALID] = 1'b1;
      if (state == S_DELAY && !ring_event_i && !silence_hit && dly_cnt == '0)
         next_events[ST_VALID] = 1'b1;
      if (state == S_IDLE && ring_event_i && !cfg.enable)
         next_events[ST_VALID] = 1'b1;
   end

   // State sequencing: idle, qualify, delay, valid
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state <= S_IDLE;
      else
      begin
         case (state)
            S_IDLE:
               if (ring_event_i)
                  state <= cfg.enable ? S_QUAL : S_VALID;
            S_QUAL:
               if (ring_event_i)
               begin
                  if (too_fast)
                     state <= S_IDLE;
               end
               else if (silence_hit)
                  state <= S_IDLE;
               else if (confirm_done)
                  state <= (delay_code == 3'h0) ? S_VALID : S_DELAY;
            S_DELAY:
               if (!ring_event_i && silence_hit)
                  state <= S_IDLE;
               else if (!ring_event_i && dly_cnt == '0)
                  state <= S_VALID;
            S_VALID:
               if (!ring_event_i && silence_hit)
                  state <= S_IDLE;
            default:
               state <= S_IDLE;
         endcase
      end
   end

   // Spacing timer: loaded on each event in idle or qualify, steps down on each 2 ms tick
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         timer <= '0;
      else if (ring_event_i && (state == S_IDLE || state == S_QUAL))
         timer <= cfg.start;
      else if (tick && timer != '0)
         timer <= timer - 1'b1;
   end

   // Confirmation window, armed on the first event of a burst
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         conf_cnt <= '0;
      else if (state == S_IDLE && ring_event_i)
         conf_cnt <= confirm_ticks(cfg.confirm);
      else if (state == S_QUAL && tick && conf_cnt != '0)
         conf_cnt <= conf_cnt - 1'b1;
   end

   // Report delay, armed as confirmation completes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dly_cnt <= '0;
      else if (state == S_QUAL && confirm_done)
         dly_cnt <= delay_ticks(delay_code);
      else if (state == S_DELAY && tick && dly_cnt != '0)
         dly_cnt <= dly_cnt - 1'b1;
   end

   // Silence since the most recent crossing; saturates to avoid wrap
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sil_cnt <= '0;
      else if (ring_event_i || state == S_IDLE)
         sil_cnt <= '0;
      else if (tick && sil_cnt != '1)
         sil_cnt <= sil_cnt + 1'b1;
   end

   // Valid ring indication lags the state by one cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ring_valid_o <= 1'b0;
      else
         ring_valid_o <= (state == S_VALID);
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_burst_start;
      state == S_IDLE && ring_event_i && cfg.enable;
   endsequence

   sequence s_qual_event;
      state == S_QUAL && ring_event_i;
   endsequence

   sequence s_confirm_to_delay;
      state == S_QUAL && !ring_event_i && !silence_hit && confirm_done && delay_code != 3'h0;
   endsequence

   a_first_load_only:
      assert property (s_burst_start |=> state == S_QUAL && timer == $past(cfg.start)
                       && conf_cnt == confirm_ticks($past(cfg.confirm)))
      else $error("first event did not only load the timer");

   a_timer_reload:
      assert property (s_qual_event ##0 !too_fast |=> state == S_QUAL && timer == $past(cfg.start))
      else $error("timer not reloaded on event");

   a_fast_reject:
      assert property (s_qual_event ##0 too_fast |=> state == S_IDLE && status[ST_FAST] ##1 !ring_valid_o)
      else $error("too fast ring not rejected");

   a_timer_steps:
      assert property (state == S_QUAL && !ring_event_i && tick && timer != '0
                       |=> timer == $past(timer) - 6'h01)
      else $error("timer did not step down");

   a_delay_armed:
      assert property (s_confirm_to_delay |=> state == S_DELAY && dly_cnt == delay_ticks($past(delay_code))
                       ##1 !ring_valid_o)
      else $error("delay not armed with coded length");

   a_timeout_end:
      assert property (state != S_IDLE && !ring_event_i && silence_hit |=> state == S_IDLE ##1 !ring_valid_o)
      else $error("ringing end not declared");

   a_bypass_valid:
      assert property (state == S_IDLE && ring_event_i && !cfg.enable |=> state == S_VALID ##1 ring_valid_o)
      else $error("bypass did not report ring");

   a_confirm_hold:
      assert property (state == S_QUAL && !confirm_done |=> state != S_DELAY && state != S_VALID)
      else $error("ring valid before confirmation time");

   a_status_sticky:
      assert property (status[ST_VALID] && !bus_rd_status |=> status[ST_VALID])
      else $error("sticky status lost");
endmodule

// [src/rvq_pkg.sv]
// Constants, types and helper functions shared by the ring validation qualifier
package rvq_pkg;

   // ****************************************************************
   // Bus layout
   // ****************************************************************
   localparam int          WB_AW        = 8;
   localparam int          WB_DW        = 32;
   localparam logic [7:0]  ADDR_CTRL1   = 8'h00;   // Delay low bits, threshold
   localparam logic [7:0]  ADDR_CTRL2   = 8'h04;   // Delay high bit, timeout, confirm
   localparam logic [7:0]  ADDR_CTRL3   = 8'h08;   // Enable, timer start value
   localparam logic [7:0]  ADDR_STATUS  = 8'h0c;   // Sticky events, cleared by read
   localparam logic [7:0]  ADDR_MASK    = 8'h10;   // Interrupt mask, same layout
   localparam logic [7:0]  ADDR_STATE   = 8'h14;   // Live qualifier state
   localparam logic [7:0]  CTRL1_RESET  = 8'h96;
   localparam logic [7:0]  CTRL2_RESET  = 8'h2d;
   localparam logic [7:0]  CTRL3_RESET  = 8'h19;

   // Status bit positions
   localparam int          ST_VALID     = 0;
   localparam int          ST_FAST      = 1;
   localparam int          ST_END       = 2;
   localparam int          ST_W         = 3;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int          CLK_PERIOD_NS   = 4;
   localparam int          TICK_PERIOD_NS  = 2000000;   // 2.0 ms qualification step
   localparam int          TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          TICK_MS         = 2;
   localparam int          DELAY_STEP_MS   = 256;
   localparam int          TIMEOUT_STEP_MS = 128;
   localparam logic [7:0][10:0] CONFIRM_MS = {11'd1024, 11'd640, 11'd512, 11'd384,
                                              11'd256, 11'd200, 11'd150, 11'd100};
   localparam int          CNT_W        = 10;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic       enable;       // ring_check_enable
      logic [5:0] start;        // Qualification timer start value
      logic       delay_high;   // valid_ring_delay_high
      logic [1:0] delay_low;    // valid_ring_delay_low
      logic [3:0] timeout;      // ringing_end_timeout
      logic [2:0] confirm;      // ring_confirm_interval
      logic [5:0] threshold;    // min_interval_threshold
   } rvq_cfg_t;

   typedef enum logic [3:0] {
      S_IDLE  = 4'h1,
      S_QUAL  = 4'h2,
      S_DELAY = 4'h4,
      S_VALID = 4'h8
   } rvq_state_t;

   // Delay code to ticks
   function automatic logic [CNT_W-1:0] delay_ticks(input logic [2:0] code);
      delay_ticks = CNT_W'(code * (DELAY_STEP_MS / TICK_MS));
   endfunction

   // Timeout code to ticks
   function automatic logic [CNT_W-1:0] timeout_ticks(input logic [3:0] code);
      timeout_ticks = CNT_W'(code * (TIMEOUT_STEP_MS / TICK_MS));
   endfunction

   // Confirmation code to ticks
   function automatic logic [CNT_W-1:0] confirm_ticks(input logic [2:0] code);
      confirm_ticks = CNT_W'(CONFIRM_MS[code] / TICK_MS);
   endfunction

endpackage

// [src/rvq_tick.sv]
// Divider that makes the one-cycle qualification step enable
`timescale 1ns/1ps
module rvq_tick #(
   parameter int DIV = 500000
) (
   input  wire logic clk_i,    // System clock
   input  wire logic rst_i,    // Synchronous reset, high
   output logic      tick_o    // One-cycle pulse every DIV cycles
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

   logic [W-1:0] cnt;

   // Free running divider; restarts on reset so the first step is a full period
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt    <= '0;
         tick_o <= 1'b0;
      end
      else if (cnt == W'(DIV - 1))
      begin
         cnt    <= '0;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt    <= cnt + 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule

// [bench/rvq_ring_src.sv]
// Behavioural tip/ring crossing source standing in for the analog detector
`timescale 1ns/1ps
module rvq_ring_src (
   input  wire logic        clk_i,    // System clock
   input  wire logic        rst_i,    // Synchronous reset, high
   input  wire logic        go_i,     // Start a burst
   input  wire logic [7:0]  count_i,  // Crossings in the burst
   input  wire logic [15:0] gap_i,    // Cycles between crossings
   output logic             event_o,  // One-cycle crossing pulse
   output logic             busy_o    // Burst still running
);
   logic [7:0]  left;
   logic [15:0] wait_cnt;

   // Crossings are single pulses; the line rests low between them like a comparator output
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         left     <= 8'h00;
         wait_cnt <= 16'h0000;
         event_o  <= 1'b0;
      end
      else
      begin
         event_o <= 1'b0;
         if (go_i)
         begin
            left     <= count_i;
            wait_cnt <= 16'h0000;
         end
         else if (left != 8'h00)
         begin
            if (wait_cnt == 16'h0000)
            begin
               event_o  <= 1'b1;
               left     <= left - 8'h01;
               wait_cnt <= gap_i - 16'h0001;
            end
            else
               wait_cnt <= wait_cnt - 16'h0001;
         end
      end
   end

   // Busy drops with the last pulse
   assign busy_o = (left != 8'h00);
endmodule

// [bench/tb.sv]
// Self-checking bench for the ring validation qualifier
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
   import rvq_pkg::*;
   // A short step keeps the longest delay code within a few thousand cycles
   localparam int               TK    = 4;
   localparam logic [5:0][7:0]  REG_A = {8'h18, 8'h14, 8'h10, 8'h08, 8'h04, 8'h00};
   localparam logic [5:0][7:0]  REG_E = {8'h00, 8'h01, 8'h00, 8'h19, 8'h2d, 8'h96};
   localparam logic [7:0][10:0] CONF  = {11'd1024, 11'd640, 11'd512, 11'd384, 11'd256, 11'd200, 11'd150, 11'd100};
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        ring_event_i, ring_valid_o, irq_o, go, busy;
   logic [7:0]  wb_adr_i, cnt;
   logic [3:0]  wb_sel_i;
   logic [15:0] gap;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   int          fail_count, checked;
   int          cyc_n = 0;

   rvq_top #(.TICK_CYCLES_P(TK)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ring_event_i(ring_event_i), .ring_valid_o(ring_valid_o), .irq_o(irq_o));
   rvq_ring_src src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .count_i(cnt), .gap_i(gap),
      .event_o(ring_event_i), .busy_o(busy));

   // Free-running clock
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // Hang guard, sized well above the longest expected run
   always @(posedge clk_i)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 60000)
      begin
         fail_count++;
         close_out();
      end
   end

   task close_out;
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ****************************************************************
   // Bus, crossing and timing helpers
   // ****************************************************************
   // Classic cycle: hold everything until ack is sampled, then release
   task wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h000000, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      if (n >= 20)
      begin
         fail_count++;
         $display("[ERR] %0t no bus acknowledge", $time);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task rdchk(input logic [7:0] a, input logic [7:0] e);
      wb_xfer(1'b0, a, 8'h00, 4'hf);
      `CHK(rd, {24'h000000, e})
   endtask

   task burst(input logic [7:0] c, input logic [15:0] g);
      @(posedge clk_i);
      go  <= 1'b1;
      cnt <= c;
      gap <= g;
      @(posedge clk_i);
      go  <= 1'b0;
   endtask

   // Stops at the edge where the design samples a crossing
   task wait_evt;
      do
         @(posedge clk_i);
      while (ring_event_i !== 1'b1);
   endtask

   task wait_valid(input logic lvl, input int lim, output int n);
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ring_valid_o !== lvl && n < lim);
   endtask

   // Step phase and pulse registering blur the count by a few cycles
   task near(input int n, input int e);
      checked++;
      if (n < e - 12 || n > e + 12)
      begin
         fail_count++;
         $display("[ERR] %0t took %0d cycles, expected %0d", $time, n, e);
      end
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_regs;
      for (int i = 0; i < 6; i++)
         rdchk(REG_A[i], REG_E[i]);
      wb_xfer(1'b1, 8'h18, 8'hff, 4'hf);
      wb_xfer(1'b1, ADDR_CTRL1, 8'h00, 4'h0);
      rdchk(8'h18, 8'h00);
      rdchk(ADDR_CTRL1, 8'h96);
   endtask

   task t_bypass;
      int n1;
      int n2;
      wb_xfer(1'b1, ADDR_MASK, 8'h05, 4'hf);
      wb_xfer(1'b1, ADDR_CTRL2, 8'h10, 4'hf);
      burst(8'd1, 16'd10);
      wait_evt;
      wait_valid(1'b1, 50, n1);
      `CHK(n1, 2)
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      wait_valid(1'b0, 1000, n2);
      near(n1 + 2 + n2, 2 * 64 * TK);
      rdchk(ADDR_STATUS, 8'h05);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
   endtask

   task t_fast;
      int n;
      // Start 20, threshold 10: spacing must be at least 10 steps
      wb_xfer(1'b1, ADDR_CTRL1, 8'h0a, 4'hf);
      wb_xfer(1'b1, ADDR_CTRL2, 8'h08, 4'hf);
      wb_xfer(1'b1, ADDR_CTRL3, 8'h94, 4'hf);
      burst(8'd1, 16'd42);
      repeat (10) @(posedge clk_i);
      rdchk(ADDR_STATE, 8'h02);
      rdchk(ADDR_STATUS, 8'h00);
      repeat (300) @(posedge clk_i);
      rdchk(ADDR_STATE, 8'h01);
      // A lone crossing meets the 200-cycle confirmation, then times out at 256
      rdchk(ADDR_STATUS, 8'h05);
      // 34 cycles hold at most 9 steps and 42 at least 10, whatever the step phase
      burst(8'd2, 16'd34);
      repeat (50) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      rdchk(ADDR_STATUS, 8'h02);
      rdchk(ADDR_STATE, 8'h01);
      burst(8'd3, 16'd42);
      repeat (100) @(posedge clk_i);
      rdchk(ADDR_STATE, 8'h02);
      rdchk(ADDR_STATUS, 8'h00);
      wait_valid(1'b1, 300, n);
      `CHK(ring_valid_o, 1'b1)
      wait_valid(1'b0, 600, n);
      `CHK(ring_valid_o, 1'b0)
      rdchk(ADDR_STATUS, 8'h05);
   endtask

   // Every confirmation and delay code, paired by index
   task t_codes;
      int n;
      int e;
      for (int i = 0; i < 8; i++)
      begin
         wb_xfer(1'b1, ADDR_CTRL1, {i[1:0], 6'd10}, 4'hf);
         wb_xfer(1'b1, ADDR_CTRL2, {i[2], 4'd1, i[2:0]}, 4'hf);
         e = TK * (int'(CONF[i]) / 2 + 128 * i);
         burst(8'(e / 42 + 4), 16'd42);
         wait_evt;
         wait_valid(1'b1, 6000, n);
         near(n, e);
         wait_valid(1'b0, 8000, n);
         // Valid must only drop once the crossings have stopped
         `CHK(busy, 1'b0)
         rdchk(ADDR_STATUS, 8'h05);
      end
   endtask

   // Main sequence
   initial
   begin
      rst_i      = 1'b1;
      wb_cyc_i   = 1'b0;
      wb_stb_i   = 1'b0;
      wb_we_i    = 1'b0;
      wb_adr_i   = 8'h00;
      wb_sel_i   = 4'h0;
      wb_dat_i   = 32'h00000000;
      go         = 1'b0;
      cnt        = 8'h00;
      gap        = 16'h0000;
      fail_count = 0;
      checked    = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_bypass;
      t_fast;
      t_codes;
      repeat (4) @(posedge clk_i);
      close_out();
   end
endmodule
